// >>> include/msq_pkg.sv
// Constants and types for the Mealy logic sequencer
// How it works
// R01: A 6-bit state register and an 8-bit output register of clocked set/reset flops.
// R02: Power-on reset forces every state and output flop to one.
// R03: The AND array forms up to 48 terms from 16 inputs and 6 state bits.
// R04: Each term takes each variable true, complemented, or ignores it.
// R05: Set and reset of each flop are the OR of selected terms.
// R06: A complement array variable may qualify terms in true or complement form.
// R07: Registers change only on a low-to-high sequencer clock transition.
// R08: Set/reset low holds, reset alone clears, set alone sets, on the rising edge.
// R09: The configuration never asserts set and reset of one flop together.
// R10: Normally the eight output pins show output register bits 0 to 7.
// R11: Input zero is an ordinary sixteenth logic input at normal levels.
// R12: Diagnostic level on input zero shows state bits, pins 6 and 7 high.
// R13: Preset option: control pin high sets all state and output bits.
// R14: While preset is high, clocking stops and all outputs are high.
// R15: After preset release, only a clock pulse after a falling edge counts.
// R16: Output-enable option: low enables the output pins, high floats them.
// R17: The control pin is preset or output enable, never both.
// R18: Array links and pin option are static parameters fixed before operation.
package msq_pkg;

	localparam int NUM_INPUTS = 16;
	localparam int NUM_STATE = 6;
	localparam int NUM_OUT = 8;
	localparam int NUM_TERMS = 48;
	localparam int NUM_VARS = NUM_INPUTS + NUM_STATE;
	localparam int NUM_SR = NUM_STATE + NUM_OUT;

	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_STATE = 4'h4;
	localparam logic [3:0] ADDR_OUTREG = 4'h8;
	localparam logic [3:0] ADDR_STATUS = 4'hC;

	localparam int CTRL_HOLD_BIT = 0;
	localparam int STATUS_COLLIDE_BIT = 0;
	localparam int STATUS_ARMED_BIT = 1;
	localparam int STATUS_PRESET_BIT = 2;

	localparam logic [NUM_STATE-1:0] STATE_RESET = 6'h3F;
	localparam logic [NUM_OUT-1:0] OUT_RESET = 8'hFF;
	localparam logic [NUM_OUT-1:0] PINS_ALL_HIGH = 8'hFF;
	localparam logic [1:0] DIAG_UPPER = 2'h3;
	localparam logic CTRL_HOLD_RESET = 1'b0;
	localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

	typedef enum {
		MSQ_WAIT_FALL,
		MSQ_RUN
	} msq_arm_type;

endpackage

// >>> core/msq_and_array.sv
// Programmable AND array and complement array of the sequencer
`timescale 1ns/1ps
module msq_and_array
	import msq_pkg::*;
#(
	parameter logic [NUM_TERMS-1:0] TERM_EN = '0,
	parameter logic [NUM_TERMS-1:0][NUM_VARS-1:0] TERM_TRUE = '0,
	parameter logic [NUM_TERMS-1:0][NUM_VARS-1:0] TERM_COMP = '0,
	parameter logic [NUM_TERMS-1:0] TERM_C_TRUE = '0,
	parameter logic [NUM_TERMS-1:0] TERM_C_COMP = '0,
	parameter logic [NUM_TERMS-1:0] COMP_SEL = '0
)(
	input wire logic [NUM_VARS-1:0] vars,
	output logic [NUM_TERMS-1:0] transition_term,
	output logic comp_var
);

	logic [NUM_TERMS-1:0] prod;

	// Both links kept on one variable inhibits the term
	always_comb begin
		for (int t = 0; t < NUM_TERMS; t++) begin
			prod[t] = &((vars | ~TERM_TRUE[t]) & (~vars | ~TERM_COMP[t])); // R03 R04
		end
	end

	// Built from the bare products so no combinational loop can form
	assign comp_var = ~|(prod & COMP_SEL); // R06

	always_comb begin
		for (int t = 0; t < NUM_TERMS; t++) begin
			transition_term[t] = TERM_EN[t] & prod[t]
				& (comp_var | ~TERM_C_TRUE[t])
				& (~comp_var | ~TERM_C_COMP[t]); // R06
		end
	end

endmodule

// >>> core/msq_sequencer.sv
// Mealy logic sequencer: arrays, set/reset registers, pins and register port
`timescale 1ns/1ps
module msq_sequencer
	import msq_pkg::*;
#(
	parameter bit PIN_IS_PRESET = 1'b1, // R18
	parameter logic [NUM_TERMS-1:0] TERM_EN = '0,
	parameter logic [NUM_TERMS-1:0][NUM_VARS-1:0] TERM_TRUE = '0,
	parameter logic [NUM_TERMS-1:0][NUM_VARS-1:0] TERM_COMP = '0,
	parameter logic [NUM_TERMS-1:0] TERM_C_TRUE = '0,
	parameter logic [NUM_TERMS-1:0] TERM_C_COMP = '0,
	parameter logic [NUM_TERMS-1:0] COMP_SEL = '0,
	parameter logic [NUM_SR-1:0][NUM_TERMS-1:0] SET_SEL = '0,
	parameter logic [NUM_SR-1:0][NUM_TERMS-1:0] RST_SEL = '0
)(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [NUM_INPUTS-1:0] logic_inputs,
	input wire logic diag_supervolt,
	input wire logic sequencer_clock,
	input wire logic preset_or_outen_pin,
	output logic [NUM_OUT-1:0] output_pins,
	output logic output_pins_oe,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata
);

	////////////////////////////////////////////////////////////////////////
	// Helpers

	// One flop of the set/reset pair; both high is kept as a hold
	function automatic logic sr_next(input logic q, input logic s, input logic r);
		unique case ({s, r})
			2'b10: sr_next = 1'b1;
			2'b01: sr_next = 1'b0;
			default: sr_next = q;
		endcase
	endfunction

	function automatic logic or_select(
		input logic [NUM_TERMS-1:0] terms,
		input logic [NUM_TERMS-1:0] sel
	);
		or_select = |(terms & sel);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Declarations

	logic [NUM_STATE-1:0] state_reg_bit_r;
	logic [NUM_OUT-1:0] output_reg_bit_r;
	logic [NUM_STATE-1:0] state_nxt;
	logic [NUM_OUT-1:0] output_nxt;
	logic [NUM_OUT-1:0] output_pins_r;
	logic output_pins_oe_r;
	logic [31:0] reg_rdata_r;
	logic clk_prev_r;
	logic ctrl_hold_r;
	logic collide_r;
	msq_arm_type arm_r;
	logic [NUM_VARS-1:0] array_vars;
	logic [NUM_INPUTS-1:0] in_vec;
	logic [NUM_TERMS-1:0] transition_term;
	logic comp_var;
	logic [NUM_SR-1:0] set_v;
	logic [NUM_SR-1:0] rst_v;
	logic async_preset;
	logic outen_active;
	logic clk_rise;
	logic clk_fall;
	logic step;

	////////////////////////////////////////////////////////////////////////
	// Pin option and clock edges

	// Only one reading of the control pin exists per build
	assign async_preset = PIN_IS_PRESET & preset_or_outen_pin; // R17
	assign outen_active = PIN_IS_PRESET | ~preset_or_outen_pin; // R16 R17

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			clk_prev_r <= 1'b0; // Idle level, so reset leaves no false fall
		end else begin
			clk_prev_r <= sequencer_clock;
		end
	end

	assign clk_rise = sequencer_clock & ~clk_prev_r;
	assign clk_fall = ~sequencer_clock & clk_prev_r;

	// Re-arm only after a falling edge so a clock already high is no pulse
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			arm_r <= MSQ_WAIT_FALL;
		end else if (async_preset) begin
			arm_r <= MSQ_WAIT_FALL; // R15
		end else begin
			unique case (arm_r)
				MSQ_WAIT_FALL: begin
					if (clk_fall) begin
						arm_r <= MSQ_RUN; // R15
					end
				end
				MSQ_RUN: begin
					arm_r <= MSQ_RUN;
				end
			endcase
		end
	end

	assign step = clk_rise & (arm_r == MSQ_RUN) & ~async_preset & ~ctrl_hold_r; // R07 R14

	////////////////////////////////////////////////////////////////////////
	// Arrays

	// Supervoltage on input zero reads as a logic one
	always_comb begin
		in_vec = logic_inputs; // R11
		if (diag_supervolt) begin
			in_vec[0] = 1'b1;
		end
	end

	assign array_vars = {state_reg_bit_r, in_vec}; // R03

	msq_and_array #(
		.TERM_EN(TERM_EN),
		.TERM_TRUE(TERM_TRUE),
		.TERM_COMP(TERM_COMP),
		.TERM_C_TRUE(TERM_C_TRUE),
		.TERM_C_COMP(TERM_C_COMP),
		.COMP_SEL(COMP_SEL)
	) u_and_array (
		.vars(array_vars),
		.transition_term(transition_term),
		.comp_var(comp_var)
	);

	always_comb begin
		for (int k = 0; k < NUM_SR; k++) begin
			set_v[k] = or_select(transition_term, SET_SEL[k]); // R05
			rst_v[k] = or_select(transition_term, RST_SEL[k]); // R05
		end
	end

	always_comb begin
		for (int k = 0; k < NUM_STATE; k++) begin
			state_nxt[k] = sr_next(state_reg_bit_r[k], set_v[k], rst_v[k]); // R08
		end
		for (int k = 0; k < NUM_OUT; k++) begin
			output_nxt[k] = sr_next(output_reg_bit_r[k], set_v[NUM_STATE+k],
				rst_v[NUM_STATE+k]); // R08
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State and output registers

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state_reg_bit_r <= STATE_RESET; // R01 R02
		end else if (async_preset) begin
			state_reg_bit_r <= STATE_RESET; // R13
		end else if (step) begin
			state_reg_bit_r <= state_nxt; // R07
		end
	end

	// Diagnostic view never disturbs this register
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			output_reg_bit_r <= OUT_RESET; // R01 R02
		end else if (async_preset) begin
			output_reg_bit_r <= OUT_RESET; // R13
		end else if (step) begin
			output_reg_bit_r <= output_nxt; // R07 R12
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output pins, one cycle behind the registers

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			output_pins_r <= PINS_ALL_HIGH;
		end else if (async_preset) begin
			output_pins_r <= PINS_ALL_HIGH; // R14
		end else if (diag_supervolt) begin
			output_pins_r <= {DIAG_UPPER, state_reg_bit_r}; // R12
		end else begin
			output_pins_r <= output_reg_bit_r; // R10
		end
	end

	// Floating the pins leaves the registers alone
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			output_pins_oe_r <= PIN_IS_PRESET;
		end else begin
			output_pins_oe_r <= outen_active; // R16
		end
	end

	assign output_pins = output_pins_r;
	assign output_pins_oe = output_pins_oe_r;

	////////////////////////////////////////////////////////////////////////
	// Register port

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			ctrl_hold_r <= CTRL_HOLD_RESET;
		end else if (reg_wr && reg_addr == ADDR_CTRL) begin
			ctrl_hold_r <= reg_wdata[CTRL_HOLD_BIT];
		end
	end

	// Configuration slip report; a new collision beats the clear
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			collide_r <= 1'b0;
		end else if (step && |(set_v & rst_v)) begin
			collide_r <= 1'b1; // R09
		end else if (reg_wr && reg_addr == ADDR_STATUS && reg_wdata[STATUS_COLLIDE_BIT]) begin
			collide_r <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			reg_rdata_r <= RDATA_ZERO;
		end else if (reg_rd) begin
			reg_rdata_r <= RDATA_ZERO;
			unique case (reg_addr)
				ADDR_CTRL: begin
					reg_rdata_r[CTRL_HOLD_BIT] <= ctrl_hold_r;
				end
				ADDR_STATE: begin
					reg_rdata_r[NUM_STATE-1:0] <= state_reg_bit_r;
				end
				ADDR_OUTREG: begin
					reg_rdata_r[NUM_OUT-1:0] <= output_reg_bit_r;
				end
				ADDR_STATUS: begin
					reg_rdata_r[STATUS_COLLIDE_BIT] <= collide_r;
					reg_rdata_r[STATUS_ARMED_BIT] <= (arm_r == MSQ_RUN);
					reg_rdata_r[STATUS_PRESET_BIT] <= async_preset;
				end
				default: begin
					reg_rdata_r <= RDATA_ZERO;
				end
			endcase
		end else begin
			reg_rdata_r <= RDATA_ZERO;
		end
	end

	assign reg_rdata = reg_rdata_r;

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge sys_clk);
	endclocking

	default disable iff (sys_rst);

	sequence s_preset_release;
		async_preset ##1 !async_preset;
	endsequence

	sequence s_clock_rise_armed;
		step;
	endsequence

	a_power_on_ones: assert property (disable iff (1'b0) // R02
		$fell(sys_rst) |-> state_reg_bit_r == STATE_RESET && output_reg_bit_r == OUT_RESET)
		else $error("registers not all ones after reset");

	a_preset_sets_all: assert property ( // R13
		async_preset |=> state_reg_bit_r == STATE_RESET && output_reg_bit_r == OUT_RESET)
		else $error("preset did not set every bit");

	a_preset_pins_high: assert property ( // R14
		async_preset |=> output_pins == PINS_ALL_HIGH && output_pins_oe)
		else $error("pins not high during preset");

	a_release_waits_fall: assert property ( // R15
		s_preset_release |-> !step ##1 (!step || $past(clk_fall)) ##1
		(!step || $past(clk_fall) || $past(clk_fall, 2)))
		else $error("clock taken before a falling edge");

	a_no_edge_stable: assert property ( // R07
		!step && !async_preset |=> $stable(state_reg_bit_r) && $stable(output_reg_bit_r))
		else $error("registers changed without a clock rise");

	a_sr_sets_bit: assert property ( // R08
		s_clock_rise_armed ##0 (set_v[0] && !rst_v[0]) |=> state_reg_bit_r[0])
		else $error("set did not set state bit 0");

	a_sr_clears_bit: assert property ( // R08
		s_clock_rise_armed ##0 (rst_v[NUM_STATE] && !set_v[NUM_STATE])
		|=> !output_reg_bit_r[0])
		else $error("reset did not clear output bit 0");

	a_sr_holds_bit: assert property ( // R08
		step && !set_v[1] && !rst_v[1] |=> state_reg_bit_r[1] == $past(state_reg_bit_r[1]))
		else $error("state bit 1 moved with no term");

	a_diag_shows_state: assert property ( // R12
		diag_supervolt && !async_preset |=>
		output_pins == {DIAG_UPPER, $past(state_reg_bit_r)})
		else $error("diagnostic view wrong");

	a_normal_shows_out: assert property ( // R10
		!diag_supervolt && !async_preset |=> output_pins == $past(output_reg_bit_r))
		else $error("pins do not follow output register");

	a_outen_floats: assert property ( // R16
		!PIN_IS_PRESET && preset_or_outen_pin |=> !output_pins_oe ##0
		$stable(output_reg_bit_r) || $past(step))
		else $error("output enable high did not float pins");

	a_hold_blocks_step: assert property ( // R07
		clk_rise && ctrl_hold_r && !async_preset
		|=> $stable(state_reg_bit_r) && $stable(output_reg_bit_r))
		else $error("registers moved while the hold bit was set");

	a_fall_arms: assert property ( // R15
		clk_fall && !async_preset |=> arm_r == MSQ_RUN)
		else $error("falling clock edge did not arm the registers");

	a_read_idle_zero: assert property (
		!reg_rd |=> reg_rdata == RDATA_ZERO)
		else $error("read data not zero outside a read");

	a_status_preset: assert property ( // R13
		reg_rd && reg_addr == ADDR_STATUS
		|=> reg_rdata[STATUS_PRESET_BIT] == $past(async_preset))
		else $error("status does not show the preset level");

endmodule

// >>> dv/msq_env.sv
// Surrounding system logic: drives the array inputs and the sequencer clock
`timescale 1ns/1ps
module msq_env
	import msq_pkg::*;
(
	input wire logic sys_clk,
	output logic [NUM_INPUTS-1:0] logic_inputs,
	output logic sequencer_clock
);
	initial begin
		logic_inputs = '0;
		sequencer_clock = 1'b0;
	end
	// Patterns chosen never to raise set and reset of one flop together
	task automatic drive(input logic [NUM_INPUTS-1:0] value);
		@(posedge sys_clk);
		logic_inputs <= value;
	endtask
	// Each clock phase spans a system clock so both levels get sampled
	task automatic step(input logic [NUM_INPUTS-1:0] value);
		drive(value);
		sequencer_clock <= 1'b0;
		@(posedge sys_clk);
		sequencer_clock <= 1'b1;
		@(posedge sys_clk);
		sequencer_clock <= 1'b0;
		repeat (3) @(posedge sys_clk);
	endtask
endmodule

// >>> dv/msq_sequencer_tb.sv
// Self-checking bench for the Mealy logic sequencer
`timescale 1ns/1ps
module msq_sequencer_tb
	import msq_pkg::*;
;
	logic sys_clk, sys_rst, diag_supervolt, sequencer_clock, pin_a, pin_b;
	logic oe_a, oe_b, reg_wr, reg_rd;
	logic [NUM_INPUTS-1:0] logic_inputs;
	logic [NUM_OUT-1:0] pins_a, pins_b;
	logic [3:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	int miscompares = 0;
	int checked = 0;

	////////////////////////////////////////////////////////////////
	function automatic logic [NUM_TERMS-1:0][NUM_VARS-1:0] f_true();
		logic [NUM_TERMS-1:0][NUM_VARS-1:0] v;
		v = '0;
		v[0][1] = 1'b1;
		v[1][2] = 1'b1;
		v[2][0] = 1'b1;
		v[3][3] = 1'b1;
		v[3][16] = 1'b1;
		v[4][4] = 1'b1;
		v[5][5] = 1'b1;
		v[6][5] = 1'b1;
		return v;
	endfunction
	function automatic logic [NUM_TERMS-1:0][NUM_VARS-1:0] f_comp();
		logic [NUM_TERMS-1:0][NUM_VARS-1:0] v;
		v = '0;
		v[0][2] = 1'b1;
		v[1][1] = 1'b1;
		return v;
	endfunction
	function automatic logic [NUM_SR-1:0][NUM_TERMS-1:0] f_sel(input bit rst);
		logic [NUM_SR-1:0][NUM_TERMS-1:0] v;
		v = '0;
		v[6][0] = !rst;
		v[0][1] = !rst;
		v[0][0] = rst;
		v[6][1] = rst;
		v[13][2] = rst;
		v[7][3] = rst;
		v[8][5] = rst;
		v[9][6] = rst;
		return v;
	endfunction
	localparam logic [NUM_TERMS-1:0][NUM_VARS-1:0] TT = f_true();
	localparam logic [NUM_TERMS-1:0][NUM_VARS-1:0] TC = f_comp();
	localparam logic [NUM_SR-1:0][NUM_TERMS-1:0] SS = f_sel(1'b0);
	localparam logic [NUM_SR-1:0][NUM_TERMS-1:0] RS = f_sel(1'b1);

	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	msq_env msq_env_i (.sys_clk(sys_clk), .logic_inputs(logic_inputs),
		.sequencer_clock(sequencer_clock));

	// Array links fixed at elaboration; second copy uses the enable option
	msq_sequencer #(.PIN_IS_PRESET(1'b1), .TERM_EN(48'h7F), .TERM_TRUE(TT), .TERM_COMP(TC),
		.TERM_C_TRUE(48'h20), .TERM_C_COMP(48'h40), .COMP_SEL(48'h10), .SET_SEL(SS),
		.RST_SEL(RS)) msq_sequencer_i (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .logic_inputs(logic_inputs),
		.diag_supervolt(diag_supervolt), .sequencer_clock(sequencer_clock),
		.preset_or_outen_pin(pin_a), .output_pins(pins_a), .output_pins_oe(oe_a),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata));
	msq_sequencer #(.PIN_IS_PRESET(1'b0), .TERM_EN(48'h7F), .TERM_TRUE(TT), .TERM_COMP(TC),
		.TERM_C_TRUE(48'h20), .TERM_C_COMP(48'h40), .COMP_SEL(48'h10), .SET_SEL(SS),
		.RST_SEL(RS)) msq_oe_i (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .logic_inputs(logic_inputs),
		.diag_supervolt(diag_supervolt), .sequencer_clock(sequencer_clock),
		.preset_or_outen_pin(pin_b), .output_pins(pins_b), .output_pins_oe(oe_b),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata());

	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input string what);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp, what);
	endtask
	task automatic look(input logic [5:0] s, input logic [7:0] o, input logic [7:0] p);
		rd_chk(ADDR_STATE, {26'h0, s}, "state");
		rd_chk(ADDR_OUTREG, {24'h0, o}, "outreg");
		chk({24'h0, pins_a}, {24'h0, p}, "pins");
		chk({31'h0, oe_a}, 32'h1, "drive");
	endtask
	task automatic conclude();
		$display("TB: %0d checks, %0d mismatches", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	task automatic t_reset();
		chk({24'h0, pins_a}, {24'h0, OUT_RESET}, "reset pins");
		look(STATE_RESET, OUT_RESET, OUT_RESET);
		rd_chk(4'hF, RDATA_ZERO, "unmapped");
		wr(4'h2, 32'hFFFF_FFFF);
		wr(ADDR_STATE, 32'h0);
		look(STATE_RESET, OUT_RESET, OUT_RESET);
		$display("TB: reset test done");
	endtask
	task automatic t_oe();
		chk({31'h0, oe_b}, 32'h1, "enabled");
		@(posedge sys_clk);
		pin_b <= 1'b1;
		repeat (2) @(posedge sys_clk);
		#1;
		chk({31'h0, oe_b}, 32'h0, "floated");
		@(posedge sys_clk);
		pin_b <= 1'b0;
		repeat (2) @(posedge sys_clk);
		#1;
		chk({23'h0, oe_b, pins_b}, 32'h1FF, "re-enabled");
		$display("TB: enable test done");
	endtask
	task automatic t_steps();
		msq_env_i.step(16'h0002);
		look(6'h3F, 8'hFF, 8'hFF);
		msq_env_i.step(16'hFFC2);
		look(6'h3E, 8'hFF, 8'hFF);
		msq_env_i.drive(16'h0004);
		diag_supervolt <= 1'b1;
		repeat (3) @(posedge sys_clk);
		#1;
		chk({24'h0, pins_a}, 32'hFE, "diag view");
		@(posedge sys_clk);
		diag_supervolt <= 1'b0;
		look(6'h3E, 8'hFF, 8'hFF);
		msq_env_i.step(16'h0008);
		look(6'h3E, 8'hFF, 8'hFF);
		msq_env_i.step(16'h0004);
		look(6'h3F, 8'hFE, 8'hFE);
		msq_env_i.step(16'h0008);
		look(6'h3F, 8'hFC, 8'hFC);
		msq_env_i.step(16'h0001);
		look(6'h3F, 8'h7C, 8'h7C);
		msq_env_i.step(16'h0030);
		look(6'h3F, 8'h74, 8'h74);
		msq_env_i.step(16'h0020);
		look(6'h3F, 8'h70, 8'h70);
		$display("TB: step test done");
	endtask
	task automatic t_hold_preset();
		wr(ADDR_CTRL, 32'h1);
		rd_chk(ADDR_CTRL, 32'h1, "hold");
		msq_env_i.step(16'h0002);
		look(6'h3F, 8'h70, 8'h70);
		wr(ADDR_CTRL, 32'h0);
		msq_env_i.step(16'h0002);
		look(6'h3E, 8'h71, 8'h71);
		@(posedge sys_clk);
		pin_a <= 1'b1;
		msq_env_i.step(16'h0004);
		look(6'h3F, 8'hFF, 8'hFF);
		rd_chk(ADDR_STATUS, 32'h4, "status in preset");
		@(posedge sys_clk);
		pin_a <= 1'b0;
		msq_env_i.step(16'h0002);
		look(6'h3F, 8'hFF, 8'hFF);
		msq_env_i.step(16'h0002);
		look(6'h3E, 8'hFF, 8'hFF);
		rd_chk(ADDR_STATUS, 32'h2, "status armed");
		$display("TB: hold and preset test done");
	endtask
	task automatic t_midreset();
		@(posedge sys_clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		#1;
		look(STATE_RESET, OUT_RESET, OUT_RESET);
		rd_chk(ADDR_STATUS, RDATA_ZERO, "status after reset");
		msq_env_i.step(16'h0002);
		look(STATE_RESET, OUT_RESET, OUT_RESET);
		$display("TB: mid-run reset test done");
	endtask

	initial begin
		sys_rst = 1'b1;
		diag_supervolt = 1'b0;
		pin_a = 1'b0;
		pin_b = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (5) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		#1;
		t_reset();
		t_oe();
		t_steps();
		t_hold_preset();
		t_midreset();
		conclude();
	end

	// Whole run needs well under a thousand cycles
	initial begin
		#200000;
		miscompares++;
		$display("CHECK FAILED at %0t: watchdog", $time);
		conclude();
	end
endmodule
